/* File: inc/asr_pkg.sv */
/*
  Constants and types shared by the asynchronous serial receiver.
  Assumes a 100 MHz system clock and a byte-addressed register port.
*/
`default_nettype none
package asr_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  // Control bits
  localparam int CTRL_RECEIVE_ENABLE = 0;
  localparam int CTRL_PORT_ENABLE = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_NINE = 3;
  // Status bits
  localparam int ST_CHAR = 0;
  localparam int ST_OVR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_BUSY = 3;
  // Event bits
  localparam int EV_CHAR = 0;
  localparam int EV_OVR = 1;
  localparam int EV_FERR = 2;
  localparam int EV_W = 3;
  // Bit timing in oversample ticks
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_DEC = 4'h9;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  // Default rate divider
  localparam longint CLK_HZ = 100000000;
  localparam longint BAUD_HZ = 9600;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (OVERSAMPLE * BAUD_HZ) - 1);
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b11,
    ASR_STOP = 2'b10
  } asr_state_t;

  typedef struct packed {
    logic ferr;
    logic [8:0] data;
  } asr_char_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } asr_bus_req_t;
endpackage
`default_nettype wire

/* File: logic/asr_rx.sv */
/*
  Asynchronous serial receiver: start detect, oversampled bit recovery,
  stop check, small receive FIFO, register port and interrupt.
  Assumes receive_pin and the register port are synchronous to sys_clk.
*/
// Overview of operation
// - Falling edge on idle line begins character
// - Recheck start bit low at its centre
// - High at start centre aborts silently
// - Step one bit period per data bit
// - Majority vote decides each shifted bit
// - Low stop bit flags framing error
// - High stop bit clears framing error
// - Stop sampled: push character, set flag
// - Data read returns and removes oldest
// - Overrun blocks reception until cleared
// - Sixteen ticks per bit, eight/nine bits
// - FIFO holds two characters plus shifting
`timescale 1ns/1ps
`default_nettype none
module asr_rx #(
  parameter int FIFO_DEPTH = 2,
  parameter int BAUD_W = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire asr_pkg::asr_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic receive_pin,
  output logic irq
);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || BAUD_W < 16 || BAUD_W > 32) begin : g_bad
    $error("asr_rx: FIFO_DEPTH must be a power of two >= 2, BAUD_W 16..32");
  end

  typedef struct packed {
    asr_pkg::asr_state_t st;
    logic continuous_receive_enable;
    logic serial_port_enable;
    logic sync;
    logic nine;
    logic [BAUD_W-1:0] baud_div;
    logic [BAUD_W-1:0] div_cnt;
    logic [3:0] tick_cnt;
    logic [3:0] bit_idx;
    logic rx_prev;
    logic s_a;
    logic s_b;
    logic [8:0] receive_shift_register;
    logic overrun;
    logic [asr_pkg::EV_W-1:0] ev_stat;
    logic [asr_pkg::EV_W-1:0] ev_mask;
    asr_pkg::asr_char_t [FIFO_DEPTH-1:0] fifo;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic [31:0] rdata;
    logic irq;
  } asr_core_t;

  asr_core_t state_reg;
  asr_core_t state_next;
  logic tick;
  logic vote;
  logic rx_en;
  logic push;
  logic pop;
  logic [3:0] nbits;
  asr_pkg::asr_char_t push_ch;
  asr_pkg::asr_char_t top_ch;

  always_comb begin
    state_next = state_reg;
    tick = (state_reg.div_cnt == '0);
    vote = (state_reg.s_a & state_reg.s_b) | (state_reg.s_a & receive_pin) | (state_reg.s_b & receive_pin);
    rx_en = state_reg.continuous_receive_enable & state_reg.serial_port_enable & ~state_reg.sync
            & ~state_reg.overrun;
    nbits = state_reg.nine ? asr_pkg::BITS_LONG : asr_pkg::BITS_SHORT;
    push = 1'b0;
    pop = 1'b0;
    push_ch.ferr = ~vote;
    push_ch.data = state_reg.nine ? state_reg.receive_shift_register
                                  : {1'b0, state_reg.receive_shift_register[8:1]};
    top_ch = (state_reg.count != '0) ? state_reg.fifo[state_reg.rptr] : '0;
    state_next.rx_prev = receive_pin;
    // Oversample tick divider
    if (tick) begin
      state_next.div_cnt = state_reg.baud_div;
    end else begin
      state_next.div_cnt = state_reg.div_cnt - BAUD_W'(1);
    end
    // Register writes, applied before hardware sets so sets win
    state_next.rdata = '0;
    if (bus_req.wr) begin
      case (bus_req.addr)
        asr_pkg::ADDR_CTRL: begin
          state_next.continuous_receive_enable = bus_req.wdata[asr_pkg::CTRL_RECEIVE_ENABLE];
          state_next.serial_port_enable = bus_req.wdata[asr_pkg::CTRL_PORT_ENABLE];
          state_next.sync = bus_req.wdata[asr_pkg::CTRL_SYNC];
          state_next.nine = bus_req.wdata[asr_pkg::CTRL_NINE];
          if (!bus_req.wdata[asr_pkg::CTRL_RECEIVE_ENABLE]) begin
            state_next.overrun = 1'b0;
          end
        end
        asr_pkg::ADDR_BAUD: begin
          state_next.baud_div = bus_req.wdata[BAUD_W-1:0];
        end
        asr_pkg::ADDR_STAT: begin
          if (bus_req.wdata[asr_pkg::ST_OVR]) begin
            state_next.overrun = 1'b0;
          end
        end
        asr_pkg::ADDR_ISTAT: begin
          state_next.ev_stat = state_reg.ev_stat & ~bus_req.wdata[asr_pkg::EV_W-1:0];
        end
        asr_pkg::ADDR_IMASK: begin
          state_next.ev_mask = bus_req.wdata[asr_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Register reads, answered one cycle later
    if (bus_req.rd) begin
      case (bus_req.addr)
        asr_pkg::ADDR_CTRL: begin
          state_next.rdata = {28'h0000000, state_reg.nine, state_reg.sync, state_reg.serial_port_enable,
                              state_reg.continuous_receive_enable};
        end
        asr_pkg::ADDR_BAUD: begin
          state_next.rdata = 32'(state_reg.baud_div);
        end
        asr_pkg::ADDR_DATA: begin
          state_next.rdata = {22'h000000, top_ch};
          pop = (state_reg.count != '0);
        end
        asr_pkg::ADDR_STAT: begin
          state_next.rdata = {28'h0000000, (state_reg.st != asr_pkg::ASR_IDLE), top_ch.ferr,
                              state_reg.overrun, (state_reg.count != '0)};
        end
        asr_pkg::ADDR_ISTAT: begin
          state_next.rdata = 32'(state_reg.ev_stat);
        end
        asr_pkg::ADDR_IMASK: begin
          state_next.rdata = 32'(state_reg.ev_mask);
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
    // Character recovery
    case (state_reg.st)
      asr_pkg::ASR_IDLE: begin
        if (rx_en && state_reg.rx_prev && !receive_pin) begin
          state_next.st = asr_pkg::ASR_START;
          state_next.tick_cnt = '0;
          state_next.bit_idx = '0;
        end
      end
      asr_pkg::ASR_START, asr_pkg::ASR_DATA, asr_pkg::ASR_STOP: begin
        if (tick) begin
          state_next.tick_cnt = state_reg.tick_cnt + 4'h1;
          if (state_reg.tick_cnt == asr_pkg::SMP_A) begin
            state_next.s_a = receive_pin;
          end
          if (state_reg.tick_cnt == asr_pkg::SMP_B) begin
            state_next.s_b = receive_pin;
          end
          if (state_reg.tick_cnt == asr_pkg::SMP_DEC) begin
            if (state_reg.st == asr_pkg::ASR_START && vote) begin
              state_next.st = asr_pkg::ASR_IDLE;
            end
            if (state_reg.st == asr_pkg::ASR_DATA) begin
              state_next.receive_shift_register = {vote, state_reg.receive_shift_register[8:1]};
            end
            if (state_reg.st == asr_pkg::ASR_STOP) begin
              state_next.st = asr_pkg::ASR_IDLE;
              if (state_reg.count == (PW + 1)'(FIFO_DEPTH)) begin
                state_next.overrun = 1'b1;
                state_next.ev_stat[asr_pkg::EV_OVR] = 1'b1;
              end else begin
                push = 1'b1;
                if (!vote) begin
                  state_next.ev_stat[asr_pkg::EV_FERR] = 1'b1;
                end
              end
            end
          end
          if (state_reg.tick_cnt == asr_pkg::LAST_TICK) begin
            if (state_reg.st == asr_pkg::ASR_START) begin
              state_next.st = asr_pkg::ASR_DATA;
            end else if (state_reg.st == asr_pkg::ASR_DATA) begin
              state_next.bit_idx = state_reg.bit_idx + 4'h1;
              if (state_reg.bit_idx == nbits - 4'h1) begin
                state_next.st = asr_pkg::ASR_STOP;
              end
            end
          end
        end
        if (!rx_en && state_reg.st != asr_pkg::ASR_STOP) begin
          state_next.st = asr_pkg::ASR_IDLE;
        end
      end
      default: begin
        state_next.st = asr_pkg::ASR_IDLE;
      end
    endcase
    // FIFO bookkeeping
    if (push) begin
      state_next.fifo[state_reg.wptr] = push_ch;
      state_next.wptr = state_reg.wptr + PW'(1);
      state_next.ev_stat[asr_pkg::EV_CHAR] = 1'b1;
    end
    if (pop) begin
      state_next.rptr = state_reg.rptr + PW'(1);
    end
    state_next.count = state_reg.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    state_next.irq = |(state_next.ev_stat & state_next.ev_mask);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
      state_reg.st <= asr_pkg::ASR_IDLE;
      state_reg.baud_div <= BAUD_W'(asr_pkg::BAUD_DIV_RST);
      state_reg.div_cnt <= BAUD_W'(asr_pkg::BAUD_DIV_RST);
      state_reg.rx_prev <= 1'b1;
      state_reg.ev_mask <= asr_pkg::MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata = state_reg.rdata;
  assign irq = state_reg.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic dec_tick;
  assign dec_tick = tick && state_reg.tick_cnt == asr_pkg::SMP_DEC;

  a_idle_edge_start: assert property (
    state_reg.st == asr_pkg::ASR_IDLE && !(rx_en && state_reg.rx_prev && !receive_pin)
    |=> state_reg.st == asr_pkg::ASR_IDLE) else $error("start entered without falling edge");
  a_start_low_hold: assert property (
    state_reg.st == asr_pkg::ASR_START && dec_tick && !vote && rx_en
    |=> state_reg.st == asr_pkg::ASR_START) else $error("confirmed start bit left start phase");
  a_start_high_abort: assert property (
    state_reg.st == asr_pkg::ASR_START && dec_tick && vote
    |=> state_reg.st == asr_pkg::ASR_IDLE && (state_reg.ev_stat & ~$past(state_reg.ev_stat)) == '0)
    else $error("bad start not aborted silently");
  a_bit_step: assert property (
    state_reg.st == asr_pkg::ASR_DATA && tick && state_reg.tick_cnt == asr_pkg::LAST_TICK && rx_en
    |=> state_reg.bit_idx == $past(state_reg.bit_idx) + 4'h1) else $error("bit index not advanced");
  a_vote_shift: assert property (
    state_reg.st == asr_pkg::ASR_DATA && dec_tick
    |=> state_reg.receive_shift_register[8] == $past(vote)) else $error("voted bit not shifted in");
  a_stop_low_ferr: assert property (
    push && !vote |=> state_reg.fifo[$past(state_reg.wptr)].ferr) else $error("low stop without framing error");
  a_stop_high_ok: assert property (
    push && vote |=> !state_reg.fifo[$past(state_reg.wptr)].ferr) else $error("high stop kept framing error");
  a_push_flag: assert property (
    push && !pop |=> state_reg.ev_stat[asr_pkg::EV_CHAR] && state_reg.count == $past(state_reg.count) + 1)
    else $error("stop sample did not store character");
  a_read_oldest: assert property (
    bus_req.rd && bus_req.addr == asr_pkg::ADDR_DATA && state_reg.count != '0
    |=> bus_rdata[9:0] == $past(top_ch) && state_reg.rptr != $past(state_reg.rptr)) else $error("data read wrong");
  a_overrun_block: assert property (
    state_reg.overrun && !bus_req.wr |=> state_reg.st == asr_pkg::ASR_IDLE [*2]) else $error("reception during overrun");
  a_tick_hold: assert property (
    state_reg.st != asr_pkg::ASR_IDLE && !tick && rx_en |=> $stable(state_reg.tick_cnt)) else $error("bit timer moved off tick");
  a_fifo_bound: assert property (
    state_reg.count <= (PW + 1)'(FIFO_DEPTH)) else $error("fifo count beyond depth");
  a_flag_level: assert property (
    state_reg.count != '0 && !(bus_req.rd && bus_req.addr == asr_pkg::ADDR_STAT) ##0 bus_req.rd == 1'b0
    |=> state_reg.count != '0) else $error("character flag dropped without read");

  // Control, overrun, interrupt and bus checks
  a_mid_frame_abort: assert property (
    (state_reg.st == asr_pkg::ASR_START || state_reg.st == asr_pkg::ASR_DATA) && !rx_en
    |=> state_reg.st == asr_pkg::ASR_IDLE) else $error("disabled receiver kept shifting");
  a_overrun_set: assert property (
    state_reg.st == asr_pkg::ASR_STOP && dec_tick && state_reg.count == (PW + 1)'(FIFO_DEPTH)
    |=> state_reg.overrun && state_reg.ev_stat[asr_pkg::EV_OVR]) else $error("full fifo did not flag overrun");
  a_sync_block: assert property (
    state_reg.sync |=> state_reg.st != asr_pkg::ASR_START && state_reg.st != asr_pkg::ASR_DATA)
    else $error("clocked mode let a frame run");
  a_push_irq: assert property (
    push && state_reg.ev_mask[asr_pkg::EV_CHAR] && !bus_req.wr |=> irq) else $error("stored character raised no irq");
  a_rdata_idle: assert property (
    !bus_req.rd |=> bus_rdata == '0) else $error("read data outside its cycle");
  a_empty_read: assert property (
    bus_req.rd && bus_req.addr == asr_pkg::ADDR_DATA && state_reg.count == '0
    |=> bus_rdata == '0 && $stable(state_reg.rptr)) else $error("empty fifo read popped");

  c_start_abort: cover property (state_reg.st == asr_pkg::ASR_START && dec_tick && vote);
  c_frame_error: cover property (push && !vote);
  c_overrun: cover property ($rose(state_reg.overrun));
  c_nine_bit: cover property (push && state_reg.nine);
  c_read_pop: cover property (pop);
endmodule
`default_nettype wire

/* File: sim/asr_tx_model.sv */
/*
  Remote serial transmitter model that drives the receive line.
  Assumes the receiver's bit period is BIT_CLKS sys_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic sys_clk,
  output logic line
);
  // Idle line is high
  initial line = 1'b1;

  // Idle gap, start, data LSB first, stop
  task automatic send(input logic [8:0] d, input int nbits, input logic stop, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    line <= stop;
    repeat (BIT_CLKS) @(posedge sys_clk);
    line <= 1'b1;
  endtask

  // Low pulse shorter than half a bit
  task automatic pulse(input int n);
    @(posedge sys_clk);
    line <= 1'b0;
    repeat (n) @(posedge sys_clk);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: sim/async_serial_receiver_test.sv */
/*
  Self-checking testbench of the serial receiver.
  Assumes the register map of asr_pkg and BAUD set to 0, one tick per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_test;
  logic sys_clk;
  logic rstn;
  logic receive_pin;
  logic irq;
  logic [31:0] bus_rdata;
  asr_pkg::asr_bus_req_t bus_req;
  int miscompares;
  int comparisons;

  asr_rx #(.FIFO_DEPTH(2), .BAUD_W(16)) dut (.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .receive_pin(receive_pin), .irq(irq));
  asr_tx_model #(.BIT_CLKS(16)) tx (.sys_clk(sys_clk), .line(receive_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge sys_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(bus_rdata, exp, msg);
  endtask

  task automatic t_basic;
    wr(asr_pkg::ADDR_BAUD, 32'h0);
    // Divider runs out its reset count before ticking every clock
    repeat (int'(asr_pkg::BAUD_DIV_RST) + 16) @(posedge sys_clk);
    wr(asr_pkg::ADDR_CTRL, 32'h3);
    wr(asr_pkg::ADDR_IMASK, 32'h1);
    rd(asr_pkg::ADDR_BAUD, 32'h0, "baud readback");
    rd(asr_pkg::ADDR_CTRL, 32'h3, "ctrl readback async");
    rd(asr_pkg::ADDR_IMASK, 32'h1, "mask readback");
    tx.send(9'h0a5, 8, 1'b1, 4);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1, "irq after char");
    rd(asr_pkg::ADDR_STAT, 32'h1, "stat char flag");
    rd(asr_pkg::ADDR_ISTAT, 32'h1, "istat char");
    rd(asr_pkg::ADDR_DATA, 32'h0a5, "data byte");
    rd(asr_pkg::ADDR_STAT, 32'h0, "stat empty");
    wr(asr_pkg::ADDR_ISTAT, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(8'h20, 32'h0, "unmapped read");
    $display("test basic done");
  endtask

  task automatic t_glitch;
    tx.pulse(4);
    rd(asr_pkg::ADDR_ISTAT, 32'h0, "glitch no event");
    rd(asr_pkg::ADDR_STAT, 32'h0, "glitch no char");
    tx.send(9'h05a, 8, 1'b1, 0);
    rd(asr_pkg::ADDR_DATA, 32'h05a, "char after glitch");
    wr(asr_pkg::ADDR_ISTAT, 32'h7);
    $display("test glitch done");
  endtask

  task automatic t_ferr;
    tx.send(9'h03c, 8, 1'b0, 2);
    rd(asr_pkg::ADDR_ISTAT, 32'h5, "istat ferr");
    rd(asr_pkg::ADDR_STAT, 32'h5, "stat ferr top");
    rd(asr_pkg::ADDR_DATA, 32'h23c, "data ferr");
    wr(asr_pkg::ADDR_ISTAT, 32'h7);
    tx.send(9'h0c3, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_DATA, 32'h0c3, "ferr cleared");
    rd(asr_pkg::ADDR_ISTAT, 32'h1, "istat no ferr");
    wr(asr_pkg::ADDR_ISTAT, 32'h7);
    $display("test ferr done");
  endtask

  task automatic t_overrun;
    tx.send(9'h011, 8, 1'b1, 2);
    tx.send(9'h022, 8, 1'b1, 0);
    tx.send(9'h033, 8, 1'b1, 0);
    tx.send(9'h044, 8, 1'b1, 1);
    rd(asr_pkg::ADDR_STAT, 32'h3, "stat overrun");
    rd(asr_pkg::ADDR_ISTAT, 32'h3, "istat overrun");
    rd(asr_pkg::ADDR_DATA, 32'h011, "oldest first");
    rd(asr_pkg::ADDR_DATA, 32'h022, "second char");
    rd(asr_pkg::ADDR_DATA, 32'h0, "nothing after overrun");
    wr(asr_pkg::ADDR_STAT, 32'h2);
    wr(asr_pkg::ADDR_ISTAT, 32'h7);
    tx.send(9'h055, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_DATA, 32'h055, "resumed after clear");
    $display("test overrun done");
  endtask

  task automatic t_nine;
    wr(asr_pkg::ADDR_CTRL, 32'hb);
    tx.send(9'h1a5, 9, 1'b1, 2);
    tx.send(9'h05a, 9, 1'b1, 0);
    rd(asr_pkg::ADDR_DATA, 32'h1a5, "nine bit high");
    rd(asr_pkg::ADDR_DATA, 32'h05a, "nine bit low");
    wr(asr_pkg::ADDR_CTRL, 32'h1);
    tx.send(9'h077, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_STAT, 32'h0, "port disabled");
    wr(asr_pkg::ADDR_CTRL, 32'h7);
    rd(asr_pkg::ADDR_CTRL, 32'h7, "ctrl readback clocked");
    tx.send(9'h066, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_STAT, 32'h0, "clocked mode ignores line");
    wr(asr_pkg::ADDR_CTRL, 32'h3);
    tx.send(9'h099, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_DATA, 32'h099, "async mode resumes");
    $display("test nine done");
  endtask

  task automatic t_reset;
    tx.send(9'h0e7, 8, 1'b1, 2);
    rd(asr_pkg::ADDR_STAT, 32'h1, "char held before reset");
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd(asr_pkg::ADDR_STAT, 32'h0, "fifo emptied by reset");
    rd(asr_pkg::ADDR_ISTAT, 32'h0, "events cleared by reset");
    rd(asr_pkg::ADDR_CTRL, 32'h0, "ctrl after reset");
    rd(asr_pkg::ADDR_BAUD, 32'(asr_pkg::BAUD_DIV_RST), "baud after reset");
    $display("test reset done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    miscompares = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_basic();
    t_glitch();
    t_ferr();
    t_overrun();
    t_nine();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
